// ---- inc/dcfm_pkg.sv ----
// Purpose: Constants and carriers for the dimming config and fault mask bank
// Assumes: One clock domain, registers reached by an internal word port
// Notes:   Offsets are register addresses of the serial interface
`default_nettype none
package dcfm_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  GEN_ADDR      = 8'h03;
	localparam logic [7:0]  MSK_ADDR      = 8'h04;
	localparam int          REG_W         = 13;
	localparam logic [12:0] GEN_RESET     = 13'h0000;
	localparam logic [12:0] MSK_RESET     = 13'h0000;
	localparam logic [12:0] GEN_WMASK     = 13'h017F;
	localparam logic [12:0] MSK_WMASK     = 13'h007F;
	// General config fields
	localparam int          VTH_POS       = 8;
	localparam int          SLEW_LSB      = 4;
	localparam int          DIV_LSB       = 2;
	localparam int          CSEL_LSB      = 0;
	// Mask fields
	localparam int          M_SERIAL_POS  = 6;
	localparam int          M_TRACE_POS   = 5;
	localparam int          M_OPEN_POS    = 4;
	localparam int          M_SHORT_POS   = 3;
	localparam int          M_PUMP_POS    = 2;
	localparam int          OH_ACT_POS    = 1;
	localparam int          M_HEAT_POS    = 0;
	// Dimming divider base exponent: 4096 = 2**12
	localparam int          DIV_BASE_LOG2 = 12;
	localparam int          N_SWITCH      = 12;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [12:0] wdata;
	} dcfm_req_s;

	typedef struct packed {
		logic       clk_err;
		logic       crc_err;
		logic       wr_err;
		logic       rd_err;
		logic       trace_break;
		logic       lamp_open;
		logic       pump_not_ready;
		logic       overheat;
		logic       heat_warning;
	} dcfm_stat_s;
endpackage
`default_nettype wire

// ---- logic/dcfm_bank.sv ----
// Purpose: General config and fault mask registers with fault and dimming logic
// Assumes: Inputs synchronous to clock; serial framing decoded upstream
// Notes:   Dimming prescaler runs on clock, gated by oscillator ticks or sampled external clock edges
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Bit 8 selects threshold pair: 0 gives short near 1V, 1 near 4.4V.
// - Slew code bits 6:4; new code reaches drivers within one dimming period.
// - Divider bits 3:2 divide dimming clock by 4096, 8192, 16384 or 32768.
// - Clock source 0, the default: internal oscillator, clock pin disabled.
// - Clock source 1: internal oscillator, driven out on the clock pin.
// - Clock source 2 or 3: clock pin is input and feeds dimming.
// - Mask bit 6 blocks serial error summary from the fault output.
// - Mask bit 5 blocks open-trace detections from the fault output.
// - Mask bit 4 blocks open-lamp detections from the fault output.
// - Mask bit 3 blocks any per-switch short bit from the fault output.
// - Mask bit 2 blocks pump-not-ready from the fault output.
// - Overheat forces all switches closed if bit 1 is zero, else open.
// - Mask bit 0 blocks heat warning from the fault output.
// - Fault output low when any status flag but overheat is high with its mask clear.
// - Serial error summary is OR of clock, CRC, write and read errors.
// - General config write sets busy until programming done; wait for low.
module dcfm_bank
	import dcfm_pkg::*;
#(
	parameter int N_SW = N_SWITCH
)(
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire dcfm_req_s         req,
	output logic [12:0]            rdata,
	output logic                   rvalid,
	input  wire dcfm_stat_s        stat,
	input  wire logic [N_SW-1:0]   per_switch_short_status,
	input  wire logic              prog_done,
	output logic                   config_busy,
	input  wire logic              osc_tick,
	input  wire logic              clkpin_i,
	output logic                   clkpin_o,
	output logic                   clkpin_oe_n,
	output logic                   dim_tick,
	output logic                   threshold_pair_select,
	output logic [2:0]             gate_slew_code,
	output logic                   force_active,
	output logic [N_SW-1:0]        force_closed,
	output logic                   serial_error_summary,
	output logic                   fault_out_n
);
	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (N_SW < 1 || N_SW > 32)
	begin : g_chk
		$error("switch count out of range");
	end

	typedef enum logic [1:0] {
		DCFM_IDLE = 2'b01,
		DCFM_BUSY = 2'b10
	} dcfm_state_e;

	logic [12:0]      general_config;
	logic [12:0]      fault_mask_config;
	dcfm_state_e      state;
	logic             clkpin_q;
	logic [14:0]      pre_cnt;
	logic [2:0]       slew_pend;
	logic             slew_pending;
	logic             src_tick;
	logic [1:0]       div_code;
	logic [1:0]       csel;
	logic             lamp_shorted_summary;
	logic             next_fault_n;

	// Divider end count for a code
	function automatic logic [14:0] div_end(input logic [1:0] code);
		logic [15:0] full;
		full = 16'h0001 << (DIV_BASE_LOG2 + int'(code));
		div_end = full[14:0] - 15'h0001;
	endfunction

	assign div_code = general_config[DIV_LSB+1:DIV_LSB];
	assign csel     = general_config[CSEL_LSB+1:CSEL_LSB];

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// General config; write blocked while busy
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			general_config <= GEN_RESET;
		else if (clk_en && req.wr && req.addr == GEN_ADDR && state == DCFM_IDLE)
			general_config <= req.wdata & GEN_WMASK;
	end

	// Fault mask config
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			fault_mask_config <= MSK_RESET;
		else if (clk_en && req.wr && req.addr == MSK_ADDR)
			fault_mask_config <= req.wdata & MSK_WMASK;
	end

	// Read port, one cycle latency
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata  <= 13'h0000;
			rvalid <= 1'b0;
		end
		else if (clk_en)
		begin
			rvalid <= req.rd;
			unique case (req.addr)
				GEN_ADDR: rdata <= general_config;
				MSK_ADDR: rdata <= fault_mask_config;
				default:  rdata <= 13'h0000;
			endcase
		end
	end

	// ****************************************************************
	// Configuration busy
	// ****************************************************************
	// Busy from accepted write until programming done
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			state <= DCFM_IDLE;
		else if (clk_en)
		begin
			unique case (state)
				DCFM_IDLE: if (req.wr && req.addr == GEN_ADDR)
					state <= DCFM_BUSY;
				DCFM_BUSY: if (prog_done)
					state <= DCFM_IDLE;
				default: state <= DCFM_IDLE;
			endcase
		end
	end
	assign config_busy = (state == DCFM_BUSY);

	assign threshold_pair_select = general_config[VTH_POS];

	// ****************************************************************
	// Dimming clock source and divider
	// ****************************************************************
	// Sample clock pin for external edge detection
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			clkpin_q <= 1'b0;
		else if (clk_en)
			clkpin_q <= clkpin_i;
	end

	// Source select: internal ticks or external rising edges
	assign src_tick    = csel[1] ? (clkpin_i & ~clkpin_q) : osc_tick;
	assign clkpin_oe_n = (csel != 2'b01);
	assign clkpin_o    = (csel == 2'b01) ? osc_tick : 1'b0;

	// Prescaler producing one tick per dimming period
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pre_cnt  <= 15'h0000;
			dim_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			dim_tick <= 1'b0;
			if (src_tick)
			begin
				if (pre_cnt >= div_end(div_code))
				begin
					pre_cnt  <= 15'h0000;
					dim_tick <= 1'b1;
				end
				else
					pre_cnt <= pre_cnt + 15'h0001;
			end
		end
	end

	// Slew code applied at dimming period boundary
	assign slew_pend    = general_config[SLEW_LSB+2:SLEW_LSB];
	assign slew_pending = (slew_pend != gate_slew_code);
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			gate_slew_code <= 3'h0;
		else if (clk_en && dim_tick && slew_pending)
			gate_slew_code <= slew_pend;
	end

	// ****************************************************************
	// Fault output and overheat action
	// ****************************************************************
	assign serial_error_summary = stat.clk_err | stat.crc_err
		| stat.wr_err | stat.rd_err;
	assign lamp_shorted_summary = |per_switch_short_status;

	// Masked OR of status flags
	always_comb
	begin
		next_fault_n = ~(
			(serial_error_summary & ~fault_mask_config[M_SERIAL_POS]) |
			(stat.trace_break     & ~fault_mask_config[M_TRACE_POS])  |
			(stat.lamp_open       & ~fault_mask_config[M_OPEN_POS])   |
			(lamp_shorted_summary & ~fault_mask_config[M_SHORT_POS])  |
			(stat.pump_not_ready  & ~fault_mask_config[M_PUMP_POS])   |
			(stat.heat_warning    & ~fault_mask_config[M_HEAT_POS]));
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			fault_out_n <= 1'b1;
		else if (clk_en)
			fault_out_n <= next_fault_n;
	end

	// Overheat forcing of all switches
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			force_active <= 1'b0;
			force_closed <= '0;
		end
		else if (clk_en)
		begin
			force_active <= stat.overheat;
			force_closed <= {N_SW{~fault_mask_config[OH_ACT_POS]}};
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_fault_heat: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && stat.heat_warning && !fault_mask_config[M_HEAT_POS] |=> !fault_out_n)
		else $error("heat warning did not assert fault");
	a_fault_idle: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en
		&& !((stat.clk_err || stat.crc_err || stat.wr_err || stat.rd_err)
			&& !fault_mask_config[M_SERIAL_POS])
		&& !(stat.trace_break && !fault_mask_config[M_TRACE_POS])
		&& !(stat.lamp_open && !fault_mask_config[M_OPEN_POS])
		&& !((|per_switch_short_status) && !fault_mask_config[M_SHORT_POS])
		&& !(stat.pump_not_ready && !fault_mask_config[M_PUMP_POS])
		&& !(stat.heat_warning && !fault_mask_config[M_HEAT_POS])
		|=> fault_out_n)
		else $error("fault asserted without cause");
	a_fault_serial: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && stat.crc_err && !fault_mask_config[M_SERIAL_POS] |=> !fault_out_n)
		else $error("serial error did not assert fault");
	a_fault_short: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && (|per_switch_short_status) && !fault_mask_config[M_SHORT_POS]
		|=> !fault_out_n)
		else $error("short did not assert fault");
	a_pin_dir: assert property (@(posedge clock) disable iff (!arst_n)
		csel[1] |-> clkpin_oe_n)
		else $error("clock pin driven while input");
	a_pin_out: assert property (@(posedge clock) disable iff (!arst_n)
		csel == 2'b01 |-> !clkpin_oe_n)
		else $error("clock pin not driven");
	a_busy_hold: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && state == DCFM_IDLE && req.wr && req.addr == GEN_ADDR |=> config_busy)
		else $error("busy not set");
	a_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
		general_config[12:9] == 4'h0 && !general_config[7] && fault_mask_config[12:7] == 6'h00)
		else $error("reserved bits set");
	a_slew_apply: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && dim_tick |=> gate_slew_code == $past(slew_pend))
		else $error("slew not applied at period");
	a_overheat_dir: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en |=> force_closed == {N_SW{~$past(fault_mask_config[OH_ACT_POS])}})
		else $error("overheat action wrong");
	a_force_follow: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en |=> force_active == $past(stat.overheat))
		else $error("overheat force not following flag");
	a_fault_lamp: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && stat.lamp_open && !fault_mask_config[M_OPEN_POS] |=> !fault_out_n)
		else $error("open lamp did not assert fault");
	a_fault_trace: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && stat.trace_break && !fault_mask_config[M_TRACE_POS] |=> !fault_out_n)
		else $error("trace break did not assert fault");
	a_fault_pump: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && stat.pump_not_ready && !fault_mask_config[M_PUMP_POS] |=> !fault_out_n)
		else $error("pump not ready did not assert fault");
	a_busy_release: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && config_busy && prog_done |=> !config_busy)
		else $error("busy not released");
	a_busy_refuse: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && config_busy && req.wr && req.addr == GEN_ADDR |=> $stable(general_config))
		else $error("general write taken while busy");
	a_read_gen: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && req.rd && req.addr == GEN_ADDR |=> rdata == $past(general_config))
		else $error("general read data wrong");
	a_freeze_slew: assert property (@(posedge clock) disable iff (!arst_n)
		!clk_en |=> $stable(gate_slew_code) && $stable(fault_mask_config))
		else $error("state moved while frozen");
endmodule
`default_nettype wire

// ---- tb/dcfm_host.sv ----
// Purpose: Register master standing in for the external controller
// Assumes: Requests change after the falling edge
// Notes:   Released lines carry inverted values, never the last request
`timescale 1ns/1ns
`default_nettype none
module dcfm_host
	import dcfm_pkg::*;
(
	input  wire logic        clock,
	output var dcfm_req_s    req,
	input  wire logic [12:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        config_busy
);
	int tmo;
	initial req = '0;
	// ****************************************************************
	// Bus cycles
	// ****************************************************************
	// Write, then hold off until general programming is over
	task automatic wr(input logic [7:0] a, input logic [12:0] d);
		@(negedge clock);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clock);
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		tmo = 0;
		while (a == GEN_ADDR && config_busy !== 1'b0 && tmo < 200)
		begin
			@(negedge clock);
			tmo++;
		end
	endtask
	// Read, answer taken one cycle after the request
	task automatic rd(input logic [7:0] a, output logic [12:0] d, output logic v);
		@(negedge clock);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 13'h0000};
		@(negedge clock);
		v = rvalid;
		d = rdata;
		req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 13'h1FFF};
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the config and fault mask bank
// Assumes: Inputs driven at the falling edge
// Notes:   Internal dimming counts use an oscillator tick on every cycle; external ones count clock pin rising edges
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dcfm_pkg::*;
	logic             clock, arst_n, osc_tick, clkpin_i, prog_done, rvalid, v;
	logic             config_busy, clkpin_o, clkpin_oe_n, dim_tick, tps;
	logic             force_active, serr, fault_out_n, clk_en;
	logic [12:0]      rdata, d;
	logic [11:0]      shorts, force_closed;
	logic [2:0]       slew;
	dcfm_stat_s       stat;
	dcfm_req_s        req;
	int               n_errors, comparisons, n, mb;
	// ****************************************************************
	// Design and controller
	// ****************************************************************
	dcfm_bank i_dcfm_bank (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .req(req),
		.rdata(rdata), .rvalid(rvalid), .stat(stat), .per_switch_short_status(shorts),
		.prog_done(prog_done), .config_busy(config_busy), .osc_tick(osc_tick),
		.clkpin_i(clkpin_i), .clkpin_o(clkpin_o), .clkpin_oe_n(clkpin_oe_n),
		.dim_tick(dim_tick), .threshold_pair_select(tps), .gate_slew_code(slew),
		.force_active(force_active), .force_closed(force_closed),
		.serial_error_summary(serr), .fault_out_n(fault_out_n));
	dcfm_host i_dcfm_host (.clock(clock), .req(req), .rdata(rdata), .rvalid(rvalid),
		.config_busy(config_busy));
	// Clock and watchdog
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial
	begin
		#(80000 * 8);
		n_errors++;
		$display("FAIL %0t watchdog expired", $time);
		tally_and_finish();
	end
	// ****************************************************************
	// Checking
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [12:0] exp);
		i_dcfm_host.rd(a, d, v);
		chk({31'h0, v}, 32'h1);
		chk({19'h0, d}, {19'h0, exp});
	endtask
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_and_reserved();
		rchk(GEN_ADDR, 13'h0000);
		rchk(MSK_ADDR, 13'h0000);
		chk({31'h0, clkpin_oe_n}, 32'h1);
		prog_done = 1'b0;
		fork
			i_dcfm_host.wr(GEN_ADDR, 13'h1F8F);
			begin
				repeat (4) @(negedge clock);
				chk({31'h0, config_busy}, 32'h1);
				prog_done = 1'b1;
			end
		join
		rchk(GEN_ADDR, 13'h010F);
		chk({31'h0, tps}, 32'h1);
		chk({31'h0, clkpin_oe_n}, 32'h1);
		i_dcfm_host.wr(MSK_ADDR, 13'h1FFF);
		rchk(MSK_ADDR, 13'h007F);
		rchk(8'h05, 13'h0000);
	endtask
	task automatic t_faults();
		for (int i = 0; i < 7; i++)
		begin
			stat = '0;
			shorts = 12'h000;
			case (i)
				0: stat.heat_warning = 1'b1;
				1: stat.pump_not_ready = 1'b1;
				2: shorts[11] = 1'b1;
				3: stat.lamp_open = 1'b1;
				4: stat.trace_break = 1'b1;
				5: stat.crc_err = 1'b1;
				default: stat.rd_err = 1'b1;
			endcase
			mb = (i == 0) ? 0 : (i < 6) ? i + 1 : 6;
			i_dcfm_host.wr(MSK_ADDR, 13'h007F & ~(13'h0001 << mb));
			repeat (2) @(negedge clock);
			chk({31'h0, fault_out_n}, 32'h0);
			chk({31'h0, serr}, {31'h0, i > 4});
			i_dcfm_host.wr(MSK_ADDR, 13'h007F);
			repeat (2) @(negedge clock);
			chk({31'h0, fault_out_n}, 32'h1);
		end
		stat = '0;
		shorts = 12'h000;
	endtask
	task automatic t_overheat();
		stat.overheat = 1'b1;
		i_dcfm_host.wr(MSK_ADDR, 13'h007D);
		repeat (2) @(negedge clock);
		chk({20'h0, force_closed}, 32'hFFF);
		chk({31'h0, force_active}, 32'h1);
		i_dcfm_host.wr(MSK_ADDR, 13'h007F);
		repeat (2) @(negedge clock);
		chk({20'h0, force_closed}, 32'h000);
		stat.overheat = 1'b0;
	endtask
	// Write while frozen must not land
	task automatic t_freeze();
		clk_en = 1'b0;
		i_dcfm_host.wr(MSK_ADDR, 13'h0000);
		clk_en = 1'b1;
		rchk(MSK_ADDR, 13'h007F);
	endtask
	// External clock pin edges feed the divider
	task automatic t_ext_clock();
		osc_tick = 1'b0;
		i_dcfm_host.wr(GEN_ADDR, 13'h0062);
		chk({31'h0, clkpin_oe_n}, 32'h1);
		for (int p = 0; p < 2; p++)
		begin
			n = 0;
			while (dim_tick !== 1'b1 && n < 20000)
			begin
				clkpin_i = ~clkpin_i;
				if (clkpin_i)
					n++;
				@(negedge clock);
			end
			clkpin_i = 1'b0;
			@(negedge clock);
		end
		chk(n, 4096);
	endtask
	task automatic t_clock_out();
		i_dcfm_host.wr(GEN_ADDR, 13'h0001);
		chk({31'h0, clkpin_oe_n}, 32'h0);
		chk({31'h0, tps}, 32'h0);
		osc_tick = 1'b1;
		#1 chk({31'h0, clkpin_o}, 32'h1);
		@(negedge clock);
		osc_tick = 1'b0;
		#1 chk({31'h0, clkpin_o}, 32'h0);
	endtask
	task automatic t_dimming();
		osc_tick = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			i_dcfm_host.wr(GEN_ADDR, 13'(k * 4 + (k + 5) * 16));
			n = 0;
			while (dim_tick !== 1'b1 && n < 20000)
			begin
				@(negedge clock);
				n++;
			end
			@(negedge clock);
			chk({29'h0, slew}, k + 5);
			n = 1;
			while (dim_tick !== 1'b1 && n < 20000)
			begin
				@(negedge clock);
				n++;
			end
			chk(n, 4096 << k);
		end
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		osc_tick = 1'b0;
		clkpin_i = 1'b0;
		prog_done = 1'b1;
		stat = '0;
		shorts = 12'h000;
		repeat (2) @(negedge clock);
		arst_n = 1'b1;
		t_reset_and_reserved();
		t_faults();
		t_overheat();
		t_freeze();
		t_clock_out();
		t_dimming();
		t_ext_clock();
		tally_and_finish();
	end
endmodule
`default_nettype wire
